//--- src/pcs_pkg.sv
// Purpose: shared constants for the peripheral clock select/divide block
// Assumes: one system clock; every source clock arrives as a tick pulse
// Notes: offsets are byte addresses on the register bus
package pcs_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_BUS_SEL = 8'h10; // bus clock source select
  localparam logic [7:0] OFS_SEL_ONE = 8'h14; // clock_source_select_one
  localparam logic [7:0] OFS_DIV_NUM = 8'h18; // clock_divider_numbers
  localparam logic [7:0] OFS_SEL_TWO = 8'h1C; // clock_source_select_two
  localparam logic [7:0] OFS_STATUS = 8'h30; // switch-in-progress flags

  // reset values of whole registers
  localparam logic [31:0] SEL_ONE_RST = 32'h3300771F;
  localparam logic [31:0] DIV_NUM_RST = 32'h00000000;
  localparam logic [31:0] SEL_TWO_RST = 32'hFFFFFFFF;
  // reserved bits of select one read back as their reset pattern
  localparam logic [31:0] SEL_ONE_RSV = 32'h0300000C;

  // field positions
  localparam int PWM_LSB = 28; // pwm_clock_source [29:28]
  localparam int TM1_LSB = 12; // second_timer_clock_source [14:12]
  localparam int TM0_LSB = 8; // first_timer_clock_source [10:8]
  localparam int SPK_LSB = 4; // speaker_pwm_clock_source [4]
  localparam int WDT_LSB = 0; // watchdog_clock_source [1:0]
  localparam int ADC_LSB = 16; // adc_clock_divisor [23:16]
  localparam int UAR_LSB = 8; // serial_port_clock_divisor [11:8]
  localparam int BUS_LSB = 0; // bus_clock_divisor [3:0]
  localparam int AUD_LSB = 0; // audio_serial_clock_source [1:0]
  localparam int BSR_LSB = 0; // bus_clock_source [2:0]

  // field reset values
  localparam logic [1:0] PWM_RST = 2'h3;
  localparam logic [2:0] TMR_RST = 3'h7;
  localparam logic SPK_RST = 1'b1;
  localparam logic [1:0] WDT_RST = 2'h3;
  localparam logic [1:0] AUD_RST = 2'h3;
  localparam logic [2:0] BSR_RST = 3'h0;
  localparam logic [2:0] BSR_LAST = 3'h2; // highest legal bus source code

  // watchdog prescale of the bus clock
  localparam int WDT_DIV = 2048;
  localparam int WDT_CW = $clog2(WDT_DIV);

  // glitch-free switch states, gray along run, drain, arm
  typedef enum logic [1:0] {
    PCS_RUN = 2'h0, // passing current source
    PCS_DRAIN = 2'h1, // waiting on old source edge
    PCS_ARM = 2'h3 // waiting on new source edge
  } pcs_state_e;

endpackage

//--- src/pcs_gfmux.sv
// Purpose: glitch-free selector between asynchronous tick sources
// Assumes: ticks are one-cycle pulses synchronous to clock
// Notes: output is silent from the old edge until the first new edge
`timescale 1ns/1ns
module pcs_gfmux #(
  parameter int SW = 2 // select width
) (
  input wire logic clock, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic [SW-1:0] rst_sel, // selection taken at reset
  input wire logic [SW-1:0] sel, // requested selection
  input wire logic [(1<<SW)-1:0] tick_in, // source ticks
  output logic tick_out, // selected tick, registered
  output logic busy // switch under way, registered
);

  typedef struct packed {
    pcs_pkg::pcs_state_e st; // switch state
    logic [SW-1:0] cur; // source being passed or awaited
    logic out; // output tick
  } pcs_mux_s;

  pcs_mux_s r, n;

  ////////////////////////////////////////////////////////////////////
  // next state: gate old off on its own edge, then arm on new edge
  always_comb begin
    n = r;
    n.out = 1'b0;
    case (r.st)
      pcs_pkg::PCS_RUN: begin
        // pass the chosen source while selection is stable
        n.out = tick_in[r.cur];
        if (sel != r.cur) begin
          n.st = pcs_pkg::PCS_DRAIN;
        end
      end
      pcs_pkg::PCS_DRAIN: begin
        // old source edge closes the gate; stalls if old clock stops
        if (tick_in[r.cur]) begin
          n.st = pcs_pkg::PCS_ARM;
          n.cur = sel;
        end
      end
      pcs_pkg::PCS_ARM: begin
        // first edge of new source opens the gate
        if (tick_in[r.cur]) begin
          n.st = pcs_pkg::PCS_RUN;
          n.out = 1'b1;
        end
      end
      default: begin
        n.st = pcs_pkg::PCS_RUN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      r.st <= pcs_pkg::PCS_RUN;
      r.cur <= rst_sel;
      r.out <= 1'b0;
    end else begin
      r <= n;
    end
  end

  assign tick_out = r.out;
  assign busy = (r.st != pcs_pkg::PCS_RUN);

endmodule

//--- src/pcs_top.sv
// Purpose: peripheral clock source selectors and clock dividers
// Assumes: each source clock is a one-cycle tick on the system clock
// Notes: registers sit on a classic Wishbone slave, one ack per access
// Notes: a switch stalls while its old source stays silent
// Notes: bus-derived selector inputs use the divided bus tick
// Notes: unmapped addresses are acked, read zero, drop writes
// Notes on behaviour
// - muxes switch glitch-free, both sources must run
// - pwm select bits 29:28, four sources
// - second timer select bits 14:12, pin code 011
// - first timer select bits 10:8, other pin
// - speaker bit 4: oscillator or doubled
// - watchdog select bits 1:0, bus/2048 code 10
// - adc divide by field 23:16 plus one
// - serial port divide by field 11:8 plus one
// - bus clock divide by field 3:0 plus one
// - audio serial select bits 1:0, third register
// - bus source select: oscillator, crystal, 16 kHz
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ns
module pcs_top #(
  parameter int AW = 8 // decoded address width
) (
  input wire logic clock, // system clock, 25 MHz
  input wire logic sys_rst, // synchronous reset, high
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // write enable
  input wire logic [AW-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // access done
  input wire logic lirc_tick, // 16 kHz oscillator tick
  input wire logic xtal_tick, // 32 kHz crystal tick
  input wire logic hso_tick, // high_speed_oscillator tick
  input wire logic hso2x_tick, // doubled oscillator tick
  input wire logic tmr0_pin_tick, // first timer pin edge
  input wire logic tmr1_pin_tick, // second timer pin edge
  input wire logic adc_src_tick, // adc source tick
  input wire logic uart_src_tick, // serial port source tick
  output logic bus_clk_tick, // divided bus clock
  output logic pwm_clk_tick, // pwm clock
  output logic tmr0_clk_tick, // first timer clock
  output logic tmr1_clk_tick, // second timer clock
  output logic spk_clk_tick, // speaker pwm clock
  output logic wdt_clk_tick, // watchdog clock
  output logic aud_clk_tick, // audio serial clock
  output logic adc_clk_tick, // adc clock
  output logic uart_clk_tick // serial port clock
);

  // all state of the block outside the selectors in one packed word
  typedef struct packed {
    logic [2:0] bsrc; // bus_clock_source
    logic [1:0] pwm; // pwm_clock_source
    logic [2:0] tm1; // second_timer_clock_source
    logic [2:0] tm0; // first_timer_clock_source
    logic spk; // speaker_pwm_clock_source
    logic [1:0] wdt; // watchdog_clock_source
    logic [1:0] aud; // audio_serial_clock_source
    logic [7:0] adiv; // adc_clock_divisor
    logic [3:0] udiv; // serial_port_clock_divisor
    logic [3:0] bdiv; // bus_clock_divisor
    logic [7:0] acnt; // adc divide counter
    logic [3:0] ucnt; // serial divide counter
    logic [3:0] bcnt; // bus divide counter
    logic [pcs_pkg::WDT_CW-1:0] wcnt; // watchdog prescale counter
    logic bus_t; // bus tick out
    logic adc_t; // adc tick out
    logic uart_t; // serial tick out
    logic w2k_t; // bus/2048 tick
    logic ack; // bus ack
    logic [31:0] dat; // bus read data
  } pcs_top_s;

  // r holds the registered state, n its next value
  pcs_top_s r, n;
  logic bsrc_tick; // selected bus source tick
  logic [6:0] busy; // per-mux switch flags

  ////////////////////////////////////////////////////////////////////
  // glitch-free selectors
  // bus clock source; reserved code 3 never gets past the write
  pcs_gfmux #(.SW(2)) u_bsrc (
    .clock(clock), .sys_rst(sys_rst),
    .rst_sel(pcs_pkg::BSR_RST[1:0]),
    .sel(r.bsrc[1:0]),
    .tick_in({1'b0, lirc_tick, xtal_tick, hso_tick}),
    .tick_out(bsrc_tick), .busy(busy[0])
  );
  // pwm pair shares one source: lirc, xtal, bus or oscillator
  pcs_gfmux #(.SW(2)) u_pwm (
    .clock(clock), .sys_rst(sys_rst), .rst_sel(pcs_pkg::PWM_RST),
    .sel(r.pwm),
    .tick_in({hso_tick, r.bus_t, xtal_tick, lirc_tick}),
    .tick_out(pwm_clk_tick), .busy(busy[1])
  );
  // second timer: pin on code 011, codes 1xx all take the oscillator
  pcs_gfmux #(.SW(3)) u_tm1 (
    .clock(clock), .sys_rst(sys_rst), .rst_sel(pcs_pkg::TMR_RST),
    .sel(r.tm1),
    .tick_in({{4{hso_tick}}, tmr1_pin_tick, r.bus_t, xtal_tick,
      lirc_tick}),
    .tick_out(tmr1_clk_tick), .busy(busy[2])
  );
  // first timer: same codes, its own pin
  pcs_gfmux #(.SW(3)) u_tm0 (
    .clock(clock), .sys_rst(sys_rst), .rst_sel(pcs_pkg::TMR_RST),
    .sel(r.tm0),
    .tick_in({{4{hso_tick}}, tmr0_pin_tick, r.bus_t, xtal_tick,
      lirc_tick}),
    .tick_out(tmr0_clk_tick), .busy(busy[3])
  );
  // speaker pwm: oscillator or its doubled tick
  pcs_gfmux #(.SW(1)) u_spk (
    .clock(clock), .sys_rst(sys_rst), .rst_sel(pcs_pkg::SPK_RST),
    .sel(r.spk),
    .tick_in({hso2x_tick, hso_tick}),
    .tick_out(spk_clk_tick), .busy(busy[4])
  );
  // watchdog: code 10 takes the bus tick prescaled by 2048
  pcs_gfmux #(.SW(2)) u_wdt (
    .clock(clock), .sys_rst(sys_rst), .rst_sel(pcs_pkg::WDT_RST),
    .sel(r.wdt),
    .tick_in({lirc_tick, r.w2k_t, xtal_tick, hso_tick}),
    .tick_out(wdt_clk_tick), .busy(busy[5])
  );
  // audio serial clock: same codes as the pwm selector
  pcs_gfmux #(.SW(2)) u_aud (
    .clock(clock), .sys_rst(sys_rst), .rst_sel(pcs_pkg::AUD_RST),
    .sel(r.aud),
    .tick_in({hso_tick, r.bus_t, xtal_tick, lirc_tick}),
    .tick_out(aud_clk_tick), .busy(busy[6])
  );

  ////////////////////////////////////////////////////////////////////
  // byte-lane merge of a write into an old word
  // lanes that are off keep their old byte
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // next state: register access, dividers, watchdog prescale
  always_comb begin
    logic [31:0] rb; // current word at the address
    logic [31:0] wv; // merged write value
    logic hit; // address is mapped
    rb = 32'h00000000;
    wv = 32'h00000000;
    hit = 1'b1;
    n = r;
    n.ack = 1'b0;
    // readback of the addressed register
    case (wb_adr_i)
      pcs_pkg::OFS_BUS_SEL: begin
        rb[pcs_pkg::BSR_LSB +: 3] = r.bsrc;
      end
      pcs_pkg::OFS_SEL_ONE: begin
        rb = pcs_pkg::SEL_ONE_RSV;
        rb[pcs_pkg::PWM_LSB +: 2] = r.pwm;
        rb[pcs_pkg::TM1_LSB +: 3] = r.tm1;
        rb[pcs_pkg::TM0_LSB +: 3] = r.tm0;
        rb[pcs_pkg::SPK_LSB] = r.spk;
        rb[pcs_pkg::WDT_LSB +: 2] = r.wdt;
      end
      pcs_pkg::OFS_DIV_NUM: begin
        rb[pcs_pkg::ADC_LSB +: 8] = r.adiv;
        rb[pcs_pkg::UAR_LSB +: 4] = r.udiv;
        rb[pcs_pkg::BUS_LSB +: 4] = r.bdiv;
      end
      pcs_pkg::OFS_SEL_TWO: begin
        rb = pcs_pkg::SEL_TWO_RST;
        rb[pcs_pkg::AUD_LSB +: 2] = r.aud;
      end
      pcs_pkg::OFS_STATUS: begin
        rb[6:0] = busy;
      end
      default: begin
        hit = 1'b0; // unmapped: ack, read zero, write dropped
      end
    endcase
    // write value: old word with the enabled lanes replaced
    wv = merge(rb, wb_dat_i, wb_sel_i);
    // one access per strobe, acked the next cycle
    if (wb_cyc_i && wb_stb_i && !r.ack) begin
      n.ack = 1'b1;
      n.dat = rb;
      // a write lands on the edge that raises ack
      if (wb_we_i && hit) begin
        case (wb_adr_i)
          pcs_pkg::OFS_BUS_SEL: begin
            // reserved source codes are refused
            if (wv[pcs_pkg::BSR_LSB +: 3] <= pcs_pkg::BSR_LAST) begin
              n.bsrc = wv[pcs_pkg::BSR_LSB +: 3];
            end
          end
          pcs_pkg::OFS_SEL_ONE: begin
            n.pwm = wv[pcs_pkg::PWM_LSB +: 2];
            n.tm1 = wv[pcs_pkg::TM1_LSB +: 3];
            n.tm0 = wv[pcs_pkg::TM0_LSB +: 3];
            n.spk = wv[pcs_pkg::SPK_LSB];
            n.wdt = wv[pcs_pkg::WDT_LSB +: 2];
          end
          pcs_pkg::OFS_DIV_NUM: begin
            n.adiv = wv[pcs_pkg::ADC_LSB +: 8];
            n.udiv = wv[pcs_pkg::UAR_LSB +: 4];
            n.bdiv = wv[pcs_pkg::BUS_LSB +: 4];
          end
          pcs_pkg::OFS_SEL_TWO: begin
            n.aud = wv[pcs_pkg::AUD_LSB +: 2];
          end
          default: begin
            n.ack = 1'b1; // status is read-only
          end
        endcase
      end
    end
    // bus clock: one pulse per (divisor+1) source ticks
    // the divided bus tick feeds the muxes and the watchdog
    n.bus_t = 1'b0;
    if (bsrc_tick) begin
      // >= so a divisor lowered mid-count ends the period now
      if (r.bcnt >= r.bdiv) begin
        n.bcnt = 4'h0;
        n.bus_t = 1'b1;
      end else begin
        // count this source tick
        n.bcnt = r.bcnt + 4'h1;
      end
    end
    // adc clock divider
    n.adc_t = 1'b0;
    if (adc_src_tick) begin
      // >= so a divisor lowered mid-count ends the period now
      if (r.acnt >= r.adiv) begin
        n.acnt = 8'h00;
        n.adc_t = 1'b1;
      end else begin
        // count this source tick
        n.acnt = r.acnt + 8'h01;
      end
    end
    // serial port clock divider
    n.uart_t = 1'b0;
    if (uart_src_tick) begin
      // >= so a divisor lowered mid-count ends the period now
      if (r.ucnt >= r.udiv) begin
        n.ucnt = 4'h0;
        n.uart_t = 1'b1;
      end else begin
        // count this source tick
        n.ucnt = r.ucnt + 4'h1;
      end
    end
    // watchdog prescale: one tick per 2048 bus ticks
    n.w2k_t = 1'b0;
    if (r.bus_t) begin
      // the wrap of the counter marks every 2048th bus tick
      n.wcnt = r.wcnt + 1'b1;
      n.w2k_t = (r.wcnt == '1);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      // counters and ticks clear; fields take their reset codes
      r <= '0;
      r.bsrc <= pcs_pkg::BSR_RST;
      r.pwm <= pcs_pkg::PWM_RST;
      r.tm1 <= pcs_pkg::TMR_RST;
      r.tm0 <= pcs_pkg::TMR_RST;
      r.spk <= pcs_pkg::SPK_RST;
      r.wdt <= pcs_pkg::WDT_RST;
      r.aud <= pcs_pkg::AUD_RST;
      r.adiv <= pcs_pkg::DIV_NUM_RST[pcs_pkg::ADC_LSB +: 8];
      r.udiv <= pcs_pkg::DIV_NUM_RST[pcs_pkg::UAR_LSB +: 4];
      r.bdiv <= pcs_pkg::DIV_NUM_RST[pcs_pkg::BUS_LSB +: 4];
    end else begin
      // hold the next state computed above
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  // selector ticks come straight from the flop inside each mux
  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign bus_clk_tick = r.bus_t;
  assign adc_clk_tick = r.adc_t;
  assign uart_clk_tick = r.uart_t;

endmodule

//--- verif/pcs_top_monitor.sv
// Purpose: port checks for the clock select/divide block
// Assumes: one clock domain, reset synchronous and high
// Notes: every output tick must trace back to a source tick
`timescale 1ns/1ns
module pcs_monitor (
  input wire logic clock, // system clock
  input wire logic sys_rst, // reset, high
  input wire logic wb_we_i, // write enable
  input wire logic wb_ack_o, // access done
  input wire logic lirc_tick, // slow oscillator
  input wire logic xtal_tick, // crystal
  input wire logic hso_tick, // fast oscillator
  input wire logic hso2x_tick, // doubled oscillator
  input wire logic tmr0_pin_tick, // first pin
  input wire logic tmr1_pin_tick, // second pin
  input wire logic adc_src_tick, // adc source
  input wire logic uart_src_tick, // serial port source
  input wire logic bus_clk_tick, // bus clock
  input wire logic pwm_clk_tick, // pwm clock
  input wire logic tmr0_clk_tick, // first timer clock
  input wire logic tmr1_clk_tick, // second timer clock
  input wire logic spk_clk_tick, // speaker clock
  input wire logic wdt_clk_tick, // watchdog clock
  input wire logic aud_clk_tick, // audio clock
  input wire logic adc_clk_tick, // adc clock
  input wire logic uart_clk_tick // serial port clock
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // sources shared by the selectors
  wire logic pool = lirc_tick | xtal_tick | hso_tick;
  wire logic pbus = pool | bus_clk_tick;
  //////////////////////////////////////////////////////////////////////
  property p_pwm_src;
    pwm_clk_tick |-> $past(pbus);
  endproperty
  a_pwm_src: assert property (p_pwm_src)
    else $error("pwm tick without a source tick");
  property p_tmr1_src;
    tmr1_clk_tick |-> $past(pbus | tmr1_pin_tick);
  endproperty
  a_tmr1_src: assert property (p_tmr1_src)
    else $error("second timer tick without a source tick");
  property p_tmr0_src;
    tmr0_clk_tick |-> $past(pbus | tmr0_pin_tick);
  endproperty
  a_tmr0_src: assert property (p_tmr0_src)
    else $error("first timer tick without a source tick");
  property p_spk_src;
    spk_clk_tick |-> $past(hso_tick | hso2x_tick);
  endproperty
  a_spk_src: assert property (p_spk_src)
    else $error("speaker tick without oscillator tick");
  property p_wdt_src;
    wdt_clk_tick |-> $past(pool) || $past(bus_clk_tick, 2);
  endproperty
  a_wdt_src: assert property (p_wdt_src)
    else $error("watchdog tick without a source tick");
  property p_adc_div;
    adc_clk_tick |-> $past(adc_src_tick);
  endproperty
  a_adc_div: assert property (p_adc_div)
    else $error("adc tick not after a source tick");
  property p_uart_div;
    uart_clk_tick |-> $past(uart_src_tick);
  endproperty
  a_uart_div: assert property (p_uart_div)
    else $error("serial port tick not after a source tick");
  property p_bus_div;
    bus_clk_tick |-> $past(pool, 2);
  endproperty
  a_bus_div: assert property (p_bus_div)
    else $error("bus tick not after a source tick");
  property p_aud_src;
    aud_clk_tick |-> $past(pbus);
  endproperty
  a_aud_src: assert property (p_aud_src)
    else $error("audio tick without a source tick");
  // main scenarios reached
  c_write: cover property (wb_ack_o && wb_we_i);
  c_wdt: cover property (wdt_clk_tick);
  c_spk: cover property (spk_clk_tick);
endmodule
bind pcs_top pcs_monitor u_pcs_monitor (.clock(clock), .sys_rst(sys_rst),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .lirc_tick(lirc_tick),
  .xtal_tick(xtal_tick), .hso_tick(hso_tick), .hso2x_tick(hso2x_tick),
  .tmr0_pin_tick(tmr0_pin_tick), .tmr1_pin_tick(tmr1_pin_tick),
  .adc_src_tick(adc_src_tick), .bus_clk_tick(bus_clk_tick),
  .pwm_clk_tick(pwm_clk_tick), .tmr0_clk_tick(tmr0_clk_tick),
  .tmr1_clk_tick(tmr1_clk_tick), .spk_clk_tick(spk_clk_tick),
  .wdt_clk_tick(wdt_clk_tick), .aud_clk_tick(aud_clk_tick),
  .adc_clk_tick(adc_clk_tick), .uart_src_tick(uart_src_tick),
  .uart_clk_tick(uart_clk_tick));

//--- verif/pcs_top_tb.sv
// Purpose: self-checking bench for the clock select/divide block
// Assumes: every source is a tick train of a known period
// Notes: output periods are compared with a table model
`timescale 1ns/1ns
module pcs_top_tb;
  logic clock = 0; // 25 MHz
  logic sys_rst = 1; // reset, high
  logic req = 0; // cycle and strobe together
  logic we = 0; // write enable
  logic [7:0] adr = 8'h00; // byte address
  logic [31:0] dat = 32'h00000000; // write data
  logic [3:0] be = 4'hF; // byte lanes
  logic [31:0] rdat, rd, v, w; // read data, last read, scratch
  logic ack; // access done
  logic [7:0] src = 8'h00; // source ticks
  wire logic [8:0] outs; // output ticks
  int cnt = 0; // free cycle count
  int seed = 32'hECE63402; // fixed seed
  int fails = 0;
  int n_compared = 0;
  int i, m, g;
  int cd[6]; // codes per selector
  int bp[3] = '{2, 5, 7}; // bus source periods
  always #20 clock = ~clock;
  // periodic tick trains: lirc 7, xtal 5, hso 2, doubled 1, pins 9 and 11
  // sources never stop, so an old source outlives every switch
  always @(posedge clock) begin
    cnt <= cnt + 1;
    src <= {2'b11, cnt % 11 == 0, cnt % 9 == 0, 1'b1, cnt % 2 == 0,
            cnt % 5 == 0, cnt % 7 == 0};
  end
  pcs_top u_pcs_top (.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(req),
    .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(be),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .lirc_tick(src[0]),
    .xtal_tick(src[1]), .hso_tick(src[2]), .hso2x_tick(src[3]),
    .tmr0_pin_tick(src[4]), .tmr1_pin_tick(src[5]),
    .adc_src_tick(src[6]), .uart_src_tick(src[7]),
    .uart_clk_tick(outs[0]), .adc_clk_tick(outs[1]),
    .bus_clk_tick(outs[2]), .pwm_clk_tick(outs[3]),
    .tmr1_clk_tick(outs[4]), .tmr0_clk_tick(outs[5]),
    .spk_clk_tick(outs[6]), .wdt_clk_tick(outs[7]),
    .aud_clk_tick(outs[8]));
  //////////////////////////////////////////////////////////////////////
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic bus cycle, held until ack is sampled high
  task wb(input logic w_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    req <= 1'b1;
    we <= w_en;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    // ack sampled high: take the data and release at this same edge
    rd = rdat;
    req <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      fails++;
      final_report;
    end
  endtask
  // cycles between the second and third pulse of one output
  task gap(input int k, output int p);
    int j;
    for (j = 0; j < 3; j++) begin
      p = 0;
      do begin
        @(negedge clock);
        p++;
      end while (outs[k] !== 1'b1 && p < 40000);
    end
    if (p >= 40000) begin
      fails++;
      final_report;
    end
  endtask
  // expected period of selector k for code c, bus clock period 6
  function automatic int mux_per(input int k, input int c);
    int std[4] = '{7, 5, 6, 2};
    case (k)
      4, 5: return c > 3 ? 2 : c == 3 ? (k == 4 ? 11 : 9) : std[c];
      6: return c ? 1 : 2;
      7: return c == 0 ? 2 : c == 1 ? 5 : c == 2 ? 6 * 2048 : 7;
      default: return std[c];
    endcase
  endfunction
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    // reset values, then an unmapped hole
    wb(0, 8'h14, 0);
    chk(rd, 32'h3300771F);
    wb(0, 8'h18, 0);
    chk(rd, 32'h00000000);
    wb(0, 8'h10, 0);
    chk(rd, 32'h00000000);
    wb(0, 8'h20, 0);
    chk(rd, 32'h00000000);
    $display("test reset done");
    // random divisors against each bus source
    v = $random(seed);
    wb(1, 8'h18, v);
    wb(0, 8'h18, 0);
    chk(rd, v & 32'h00FF0F0F);
    gap(1, g);
    chk(g, v[23:16] + 1);
    gap(0, g);
    chk(g, v[11:8] + 1);
    for (i = 0; i < 3; i++) begin
      wb(1, 8'h10, i);
      repeat (20) @(posedge clock); // old ticks drain out of the divider
      gap(2, g);
      chk(g, bp[i] * (v[3:0] + 1));
    end
    wb(1, 8'h10, 3);
    wb(0, 8'h10, 0);
    chk(rd, 32'h00000002);
    // one byte lane only: the bus divisor changes, the rest stays
    be <= 4'h1;
    wb(1, 8'h18, 32'hFFFFFFFF);
    be <= 4'hF;
    wb(0, 8'h18, 0);
    chk(rd, (v & 32'h00FF0F00) | 32'h0000000F);
    wb(1, 8'h10, 0);
    wb(1, 8'h18, 32'h00000002);
    $display("test dividers done");
    // every selector code, reserved bits random
    for (i = 0; i < 8; i++) begin
      cd = '{i % 4, i, 7 - i, i % 2, i < 4 ? i : 0, i % 4};
      w = ($random(seed) & ~32'h30007713) | cd[0] << 28 | cd[1] << 12;
      w = w | cd[2] << 8 | cd[3] << 4 | cd[4];
      wb(1, 8'h14, w);
      wb(0, 8'h14, 0);
      chk(rd, (w & 32'h30007713) | 32'h0300000C);
      wb(1, 8'h1C, i % 4);
      wb(0, 8'h1C, 0);
      chk(rd, 32'hFFFFFFFC | i % 4);
      for (m = 3; m < 9; m++) begin
        gap(m, g);
        chk(g, mux_per(m, cd[m - 3]));
      end
    end
    $display("test selectors done");
    // every switch has finished, so no busy flag stands
    wb(0, 8'h30, 0);
    chk(rd, 32'h00000000);
    // mid-run reset puts every select field back
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    wb(0, 8'h14, 0);
    chk(rd, 32'h3300771F);
    wb(0, 8'h1C, 0);
    chk(rd, 32'hFFFFFFFF);
    wb(0, 8'h10, 0);
    chk(rd, 32'h00000000);
    $display("test second reset done");
    final_report;
  end
endmodule
